/* shift_reg_consts.svh */
// Offsets, field positions, reset values and sizes of the shift register block
`ifndef SHIFT_REG_CONSTS_SVH
`define SHIFT_REG_CONSTS_SVH

// ==========================================
// Register map
`define SHR_ADDR_W 4
`define SHR_CTRL_ADDR 4'h0
`define SHR_STATUS_ADDR 4'h4

// ==========================================
// Field positions
`define SHR_CTRL_RUN_BIT 0
`define SHR_STATUS_STAGE_LSB 0
`define SHR_STATUS_INV_BIT 4
`define SHR_STATUS_NOT_EMPTY_BIT 8
`define SHR_STATUS_FULL_BIT 9

// ==========================================
// Reset values and sizes
`define SHR_CTRL_RESET 1'h0
`define SHR_STAGE_RESET 4'h0
`define SHR_FIFO_DEPTH 8
`define SHR_FIFO_WIDTH 7

`endif

/* shift_reg_pkg.sv */
// Types shared by the shift register block
package shift_reg_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_t;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_STATUS = 2'b01,
    SEL_NONE = 2'b10
  } reg_sel_t;

  typedef struct packed {
    logic [3:0] stage;
    logic inv;
  } stage_state_t;

  typedef struct packed {
    logic run;
    logic awready;
    logic aw_got;
    logic [3:0] awaddr;
    logic wready;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    resp_t bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    resp_t rresp;
  } bus_state_t;

endpackage

/* shift_reg_top.sv */
// Four-stage shift register with input FIFO and AXI4-Lite control port
//
// Functional notes
// - A high load select makes the register shift right, a low one makes it load.
// - Each shift step moves every stage one place toward the last and feeds stage 0.
// - In shift, set high with hold_n high sets stage 0, both low clear it.
// - In shift, set high with hold_n low toggles stage 0, set low with hold_n high keeps it.
// - In load, each step copies the four load values into the stages, ignoring set/hold.
// - A low clear_n zeroes all stages at once without the clock, inverted output high.
// - An extra output always carries the inverse of the last stage.
// - Transfers happen only on a rising clock edge, never between edges.
`timescale 1ns/10ps
`include "shift_reg_consts.svh"

// ==========================================
// Generic FIFO
module shift_reg_fifo #(
  parameter int WIDTH = `SHR_FIFO_WIDTH,
  parameter int DEPTH = `SHR_FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
    logic full;
    logic not_empty;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = i_in_valid && !st.full;
  assign pop = i_out_ready && st.not_empty;
  assign o_in_ready = !st.full;
  assign o_out_valid = st.not_empty;
  assign o_out_data = mem[st.rptr];

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rptr = st.rptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
    // Flags registered so the full flag can drive a top-level port directly
    next_st.full = (next_st.count == (PW+1)'(DEPTH));
    next_st.not_empty = (next_st.count != '0);
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Storage left out of reset: contents are only read once written
  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem[st.wptr] <= i_in_data;
    end
  end
endmodule // shift_reg_fifo

// ==========================================
// Four stages with asynchronous clear
module shift_reg_stages (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clear_n,
  input wire logic i_step,
  input wire logic i_load_select_n,
  input wire logic i_set,
  input wire logic i_hold_n,
  input wire logic [3:0] i_load_value_in,
  output logic [3:0] o_stage_outputs,
  output logic o_last_stage_inverted
);
  import shift_reg_pkg::*;

  stage_state_t st;
  stage_state_t next_st;
  logic chk_off;

  assign chk_off = i_rst || !i_clear_n;
  assign o_stage_outputs = st.stage;
  assign o_last_stage_inverted = st.inv;

  always_comb
  begin
    next_st = st;
    if (i_step)
    begin
      if (!i_load_select_n)
      begin
        next_st.stage = i_load_value_in;
      end
      else
      begin
        next_st.stage[3:1] = st.stage[2:0];
        case ({i_set, i_hold_n})
          2'b11: next_st.stage[0] = 1'b1;
          2'b00: next_st.stage[0] = 1'b0;
          2'b10: next_st.stage[0] = ~st.stage[0];
          default: next_st.stage[0] = st.stage[0];
        endcase
      end
    end
    // Inverse taken from the next value so both flops change on the same edge
    next_st.inv = ~next_st.stage[3];
  end

  always_ff @(posedge i_core_clk or posedge i_rst or negedge i_clear_n)
  begin
    if (i_rst)
    begin
      st <= '{stage: `SHR_STAGE_RESET, inv: 1'b1};
    end
    else if (!i_clear_n)
    begin
      st <= '{stage: `SHR_STAGE_RESET, inv: 1'b1};
    end
    else
    begin
      st <= next_st;
    end
  end

  AST_SHIFT_MOVES: assert property (@(posedge i_core_clk) disable iff (chk_off)
    i_step && i_load_select_n |=> st.stage[3:1] == $past(st.stage[2:0]))
    else $error("shift did not move the stages");
  AST_FIRST_SET: assert property (@(posedge i_core_clk) disable iff (chk_off)
    i_step && i_load_select_n && i_set && i_hold_n |=> st.stage[0])
    else $error("stage 0 not set");
  AST_FIRST_CLEAR: assert property (@(posedge i_core_clk) disable iff (chk_off)
    i_step && i_load_select_n && !i_set && !i_hold_n |=> !st.stage[0])
    else $error("stage 0 not cleared");
  AST_FIRST_TOGGLE: assert property (@(posedge i_core_clk) disable iff (chk_off)
    i_step && i_load_select_n && i_set && !i_hold_n |=> st.stage[0] != $past(st.stage[0]))
    else $error("stage 0 did not toggle");
  AST_FIRST_KEEP: assert property (@(posedge i_core_clk) disable iff (chk_off)
    i_step && i_load_select_n && !i_set && i_hold_n |=> $stable(st.stage[0]))
    else $error("stage 0 not kept");
  AST_LOAD_COPY: assert property (@(posedge i_core_clk) disable iff (chk_off)
    i_step && !i_load_select_n |=> st.stage == $past(i_load_value_in))
    else $error("load did not copy values");
  AST_CLEAR_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clear_n |-> st.stage == 4'h0 && st.inv)
    else $error("clear did not zero stages");
  AST_INVERSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st.inv == ~st.stage[3])
    else $error("inverted output wrong");
  AST_NO_STEP_HOLD: assert property (@(posedge i_core_clk) disable iff (chk_off)
    !i_step |=> $stable(st.stage))
    else $error("stages changed without a step");
  AST_CLEAR_RELEASE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(i_clear_n) |-> st.stage == 4'h0)
    else $error("stages not zero after clear release");
endmodule // shift_reg_stages

// ==========================================
// Top: FIFO, stages and register slave
module shift_reg_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clear_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic i_load_select_n,
  input wire logic i_set,
  input wire logic i_hold_n,
  input wire logic [3:0] i_load_value_in,
  output logic [3:0] o_stage_outputs,
  output logic o_last_stage_inverted,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [3:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output shift_reg_pkg::resp_t o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [3:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output shift_reg_pkg::resp_t o_rresp
);
  import shift_reg_pkg::*;

  function automatic reg_sel_t decode(input logic [3:0] addr);
    case (addr)
      `SHR_CTRL_ADDR: decode = SEL_CTRL;
      `SHR_STATUS_ADDR: decode = SEL_STATUS;
      default: decode = SEL_NONE;
    endcase
  endfunction

  bus_state_t st;
  bus_state_t next_st;
  logic fifo_valid;
  logic fifo_not_full;
  logic [`SHR_FIFO_WIDTH-1:0] fifo_data;
  logic step;
  logic [31:0] status_word;
  reg_sel_t wsel;

  // Stepping only while run is set lets software stall the FIFO drain
  assign step = fifo_valid && st.run;
  assign o_in_ready = fifo_not_full;

  shift_reg_fifo #(
    .WIDTH(`SHR_FIFO_WIDTH),
    .DEPTH(`SHR_FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(i_in_valid),
    .o_in_ready(fifo_not_full),
    .i_in_data({i_load_select_n, i_set, i_hold_n, i_load_value_in}),
    .o_out_valid(fifo_valid),
    .i_out_ready(st.run),
    .o_out_data(fifo_data)
  );

  shift_reg_stages u_stages (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear_n(i_clear_n),
    .i_step(step),
    .i_load_select_n(fifo_data[6]),
    .i_set(fifo_data[5]),
    .i_hold_n(fifo_data[4]),
    .i_load_value_in(fifo_data[3:0]),
    .o_stage_outputs(o_stage_outputs),
    .o_last_stage_inverted(o_last_stage_inverted)
  );

  assign o_awready = st.awready;
  assign o_wready = st.wready;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = st.arready;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;

  always_comb
  begin
    status_word = 32'h0;
    status_word[`SHR_STATUS_STAGE_LSB +: 4] = o_stage_outputs;
    status_word[`SHR_STATUS_INV_BIT] = o_last_stage_inverted;
    status_word[`SHR_STATUS_NOT_EMPTY_BIT] = fifo_valid;
    status_word[`SHR_STATUS_FULL_BIT] = !fifo_not_full;
  end

  always_comb
  begin
    next_st = st;
    wsel = decode(st.awaddr);
    // Address and data may arrive in either order
    if (i_awvalid && st.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = i_awaddr;
    end
    if (i_wvalid && st.wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wsel == SEL_CTRL && st.wstrb[0])
      begin
        next_st.run = st.wdata[`SHR_CTRL_RUN_BIT];
      end
    end
    if (st.bvalid && i_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    if (i_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      case (decode(i_araddr))
        SEL_CTRL:
        begin
          next_st.rdata = {31'h0, st.run};
          next_st.rresp = RESP_OKAY;
        end
        SEL_STATUS:
        begin
          next_st.rdata = status_word;
          next_st.rresp = RESP_OKAY;
        end
        default:
        begin
          next_st.rdata = 32'h0;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && i_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule // shift_reg_top

/* stream_source.sv */
// Behavioural source that feeds stage words into the block's input FIFO
`timescale 1ns/10ps

// ==========================================
// Word source
module stream_source (
  input wire logic i_core_clk,
  input wire logic i_in_ready,
  output logic o_in_valid,
  output logic [6:0] o_word
);
  logic [6:0] q[$];

  initial
  begin
    o_in_valid = 1'b0;
    o_word = 7'h00;
  end

  // Word held until taken; idle bus toggles so stale data never looks valid
  always @(posedge i_core_clk)
  begin
    if (o_in_valid && i_in_ready)
      void'(q.pop_front());
    if (q.size() > 0)
    begin
      o_in_valid <= 1'b1;
      o_word <= q[0];
    end
    else
    begin
      o_in_valid <= 1'b0;
      o_word <= ~o_word;
    end
  end
endmodule // stream_source

/* tb_jk_input_shift_register_4bit.sv */
// Self-checking bench of the four-stage register block
`timescale 1ns/10ps
`include "shift_reg_consts.svh"

module tb_jk_input_shift_register_4bit;
  import shift_reg_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_clear_n = 1'b1;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, in_valid, o_in_ready;
  logic o_last_stage_inverted;
  logic [3:0] o_stage_outputs;
  logic [31:0] o_rdata, d;
  logic [6:0] word;
  resp_t o_bresp, o_rresp, r;
  logic [3:0] e;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  // Fields: load_select_n, set, hold_n, load_value_in[3:0]
  logic [6:0] words[9] = '{7'h3A, 7'h70, 7'h40, 7'h60, 7'h50, 7'h60, 7'h25, 7'h7F, 7'h40};

  always #5 i_core_clk = ~i_core_clk;

  stream_source src_u (.i_core_clk(i_core_clk), .i_in_ready(o_in_ready),
    .o_in_valid(in_valid), .o_word(word));

  shift_reg_top dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clear_n(i_clear_n),
    .i_in_valid(in_valid), .o_in_ready(o_in_ready), .i_load_select_n(word[6]),
    .i_set(word[5]), .i_hold_n(word[4]), .i_load_value_in(word[3:0]),
    .o_stage_outputs(o_stage_outputs), .o_last_stage_inverted(o_last_stage_inverted),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp));

  // ==========================================
  // Helpers
  function automatic logic [3:0] nxt(input logic [3:0] q, input logic [6:0] w);
    logic b0;
    b0 = w[5] ? (w[4] ? 1'b1 : ~q[0]) : (w[4] ? q[0] : 1'b0);
    return w[6] ? {q[2:0], b0} : w[3:0];
  endfunction

  function automatic logic [31:0] sts(input logic [3:0] q, input logic ne, input logic full);
    return {22'h0, full, ne, 3'h0, ~q[3], q};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic timeout(input string what);
    num_errors++;
    $display("unexpected timeout in %s", what);
    final_report();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input resp_t exp, input resp_t got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // ==========================================
  // AXI4-Lite master
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output resp_t rs);
    int k;
    @(posedge i_core_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= v;
    i_wstrb <= 4'hF;
    i_bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_core_clk);
      if (o_awready)
        i_awvalid <= 1'b0;
      if (o_wready)
        i_wvalid <= 1'b0;
      if (o_bvalid)
        break;
    end
    if (k == 50)
      timeout("write");
    rs = o_bresp;
    i_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output resp_t rs);
    int k;
    @(posedge i_core_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_core_clk);
      if (o_arready)
        i_arvalid <= 1'b0;
      if (o_rvalid)
        break;
    end
    if (k == 50)
      timeout("read");
    v = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask

  // Source idle before the read, so the captured status already holds every word
  task automatic drain(output logic [31:0] v);
    resp_t rs;
    int k;
    logic idle;
    for (k = 0; k < 60; k++)
    begin
      idle = (src_u.q.size() == 0) && !in_valid;
      rd(`SHR_STATUS_ADDR, v, rs);
      if (idle && !v[8])
        break;
    end
    if (k == 60)
      timeout("drain");
  endtask

  // ==========================================
  // Tests
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(`SHR_STATUS_ADDR, d, r);
    chk("status after reset", sts(4'h0, 1'b0, 1'b0), d);
    rd(`SHR_CTRL_ADDR, d, r);
    chk("ctrl after reset", 32'h0, d);
    chk_resp("ctrl read resp", RESP_OKAY, r);
    rd(4'h8, d, r);
    chk_resp("unmapped read resp", RESP_SLVERR, r);
    chk("unmapped read data", 32'h0, d);
    wr(4'hC, 32'h1, r);
    chk_resp("unmapped write resp", RESP_SLVERR, r);
    wr(`SHR_STATUS_ADDR, 32'hFFFF_FFFF, r);
    chk_resp("status write resp", RESP_OKAY, r);
    $display("test register map done");

    e = 4'h0;
    foreach (words[i])
    begin
      src_u.q.push_back(words[i]);
      e = nxt(e, words[i]);
    end
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_core_clk);
      if (!o_in_ready)
        break;
    end
    chk("in_ready when full", 32'h0, {31'h0, o_in_ready});
    rd(`SHR_STATUS_ADDR, d, r);
    chk("status while stalled", sts(4'h0, 1'b1, 1'b1), d);
    wr(`SHR_CTRL_ADDR, 32'h1, r);
    chk_resp("ctrl write resp", RESP_OKAY, r);
    rd(`SHR_CTRL_ADDR, d, r);
    chk("ctrl readback", 32'h1, d);
    drain(d);
    chk("status after drain", sts(e, 1'b0, 1'b0), d);
    $display("test fill and drain done");

    foreach (words[i])
    begin
      src_u.q.push_back(words[i]);
      e = nxt(e, words[i]);
      drain(d);
      chk("stage step", sts(e, 1'b0, 1'b0), d);
    end
    // Stage n fed back to load value n-1 gives a left shift
    src_u.q.push_back({3'b000, 1'b1, e[3:1]});
    e = {1'b1, e[3:1]};
    drain(d);
    chk("left shift", sts(e, 1'b0, 1'b0), d);
    $display("test single steps done");

    // Word parked in the FIFO across the clear must not reach the stages early
    wr(`SHR_CTRL_ADDR, 32'h0, r);
    src_u.q.push_back(7'h09);
    repeat (4) @(posedge i_core_clk);
    i_clear_n <= 1'b0;
    #1;
    chk("outputs in clear", 32'h10, {27'h0, o_last_stage_inverted, o_stage_outputs});
    @(posedge i_core_clk);
    i_clear_n <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk("after clear", 32'h10, {27'h0, o_last_stage_inverted, o_stage_outputs});
    rd(`SHR_STATUS_ADDR, d, r);
    chk("status after release", sts(4'h0, 1'b1, 1'b0), d);
    wr(`SHR_CTRL_ADDR, 32'h1, r);
    drain(d);
    chk("load after clear", sts(4'h9, 1'b0, 1'b0), d);
    $display("test clear done");
    final_report();
  end
endmodule // tb_jk_input_shift_register_4bit
